// ---- housekeeping.sv ----
// Housekeeping: serial control slave, soft reset, status/interrupt,
// bias enables and system clock startup sequencing.
// Assumes serial clock slow enough for several core cycles per phase.
//
// Contract
// - Command 01 asserts reset on eighth serial edge, releases at select rise.
// - Interrupt active while any status bit and its enable are both set.
// - Enabling a bit whose status is already set also raises interrupt.
// - Interrupt is active low open drain, released otherwise.
// - Status is 8-bit read-only at 08, reset 00, fixed bit meanings.
// - Startup done sets at delay end when enabled, clears on read.
// - Conversion done bit sets on sequence end, clears on read.
// - Bit 5 follows any threshold flag; cleared by reading that register.
// - Bit 4 follows any enabled comparator crossing flag.
// - Bits 3 and 2 follow synthesiser two and one state bits.
// - Bits 1 and 0 follow any enabled receive or transmit flag.
// - Interrupt mask is write-only at 09, reset 80.
// - Bias control write-only at 10, reset 00, bits 1 and 0 used.
// - Buffered bias pin floats while buffer enable is zero.
// - Before clock runs only clock, status and reset accesses are accepted.
// - Host writes PLL configs first; clock control write starts generator.
// - After clock control write, clock registers ignore writes until reset.
// - Clock control 16-bit write-only at 11, reset 0000, fields fixed.
// - Write starts startup counter on divider ticks; end enables clock.
// - Delay code n gives two to the n divider ticks, codes above 14 illegal.
// - Reset command acts as the reset pin on everything but the serial engine.
// - Divider field divides by 1 to 128, zero means 128.
`timescale 1ns/1ns
`default_nettype none

module housekeeping
  import housekeeping_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        serial_clock_i,
  input  wire logic        serial_port_select_n_i,
  input  wire logic        command_data_i,
  output logic             reply_data_o,
  input  wire status_src_s status_src_i,
  output logic             interrupt_out_n_o,
  output logic             interrupt_oe_o,
  output logic             midrail_bias_en_o,
  output logic             bias_buffer_en_o,
  output logic             buffered_bias_oe_o,
  output logic [15:0]      clock_control_o,
  output logic [15:0]      clock_pll_config_a_o,
  output logic [15:0]      clock_pll_config_b_o,
  output logic             clock_gen_on_o,
  output logic             sys_clk_enable_o,
  output logic             soft_reset_o
);

  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  csn_s;
    logic [1:0]  din_s;
    port_phase_e phase;
    logic [4:0]  bit_cnt;
    logic [4:0]  len;
    logic [7:0]  addr;
    logic [15:0] shin;
    logic [7:0]  shout;
    logic        is_read;
    logic        reply;
    logic        soft_rst;
    logic [7:0]  mask;
    logic [7:0]  bias;
    logic [15:0] cc;
    logic [15:0] pll_a;
    logic [15:0] pll_b;
    logic        cc_lock;
    logic [6:0]  div_cnt;
    logic [20:0] su_cnt;
    logic        clk_run;
    logic        st_done;
    logic        st_conv;
    logic        irq;
  } state_s;

  localparam state_s STATE_RST = '{
    sclk_s: 3'h0, csn_s: 3'h7, din_s: 2'h0, phase: PH_IDLE,
    bit_cnt: 5'h00, len: 5'h00, addr: 8'h00, shin: 16'h0000,
    shout: 8'h00, is_read: 1'b0, reply: 1'b0, soft_rst: 1'b0,
    mask: MASK_RST, bias: BIAS_RST, cc: CC_RST, pll_a: PLL_RST,
    pll_b: PLL_RST, cc_lock: 1'b0, div_cnt: 7'h00,
    su_cnt: 21'h00_0000, clk_run: 1'b0, st_done: 1'b0,
    st_conv: 1'b0, irq: 1'b0};

  state_s state_reg;
  state_s state_next;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        csn_rise;
  logic        csn_high;
  logic        din;
  logic [7:0]  status_now;
  logic [7:0]  addr_byte;
  logic [15:0] wr_word;
  logic        rd_cap;
  logic        wr_commit;
  logic        allowed;
  logic        div_tick;
  logic [21:0] su_pow;
  logic [20:0] su_end;
  logic        done_set;

  // Edges of the synchronised pins; first stages feed only second stages
  assign sclk_rise = state_reg.sclk_s[1] & ~state_reg.sclk_s[2];
  assign sclk_fall = ~state_reg.sclk_s[1] & state_reg.sclk_s[2];
  assign csn_rise  = state_reg.csn_s[1] & ~state_reg.csn_s[2];
  assign csn_high  = state_reg.csn_s[1];
  assign din       = state_reg.din_s[1];
  assign addr_byte = {state_reg.shin[6:0], din};
  assign wr_word   = {state_reg.shin[14:0], din};

  // Live status word, sticky bits plus source levels
  assign status_now = {
    state_reg.st_done,
    state_reg.st_conv,
    |status_src_i.aux_converter_threshold_flags,
    |(status_src_i.comparator_crossing_flags
      & status_src_i.comparator_flag_enables),
    |status_src_i.synth_two_state,
    |status_src_i.synth_one_state,
    |(status_src_i.receive_flags
      & status_src_i.receive_flag_enables),
    |(status_src_i.transmit_flags
      & status_src_i.transmit_flag_enables)};

  // Divider tick; field minus one wraps to 127 for a zero field
  assign div_tick = state_reg.div_cnt
                    == (state_reg.cc[CC_DIV_HI:CC_DIV_LO] - DIV_ONE);
  assign su_pow   = SU_POW1 << state_reg.cc[CC_DLY_HI:CC_DLY_LO];
  assign su_end   = su_pow[SU_W-1:0] - SU_ONE;
  assign done_set = state_reg.cc_lock & ~state_reg.clk_run & div_tick
                    & (state_reg.su_cnt == su_end)
                    & state_reg.cc[CC_SU_EN];

  // Accesses accepted while the system clock is still stopped
  assign allowed = state_reg.clk_run
                   | (addr_byte == ADDR_STATUS)
                   | (addr_byte == ADDR_CLOCK_CTRL)
                   | (addr_byte == ADDR_PLL_CFG_A)
                   | (addr_byte == ADDR_PLL_CFG_B);

  // Next-state logic for the whole block
  always_comb begin
    state_next = state_reg;
    rd_cap     = 1'b0;
    wr_commit  = 1'b0;
    state_next.sclk_s = {state_reg.sclk_s[1:0], serial_clock_i};
    state_next.csn_s  = {state_reg.csn_s[1:0], serial_port_select_n_i};
    state_next.din_s  = {state_reg.din_s[0], command_data_i};

    // Serial frame sequencing
    if (csn_high) begin
      state_next.phase = PH_IDLE;
    end else begin
      case (state_reg.phase)
        PH_IDLE: begin
          state_next.phase   = PH_ADDR;
          state_next.bit_cnt = '0;
          state_next.shin    = '0;
        end
        PH_ADDR: begin
          if (sclk_rise) begin
            state_next.shin    = wr_word;
            state_next.bit_cnt = state_reg.bit_cnt + CNT_ONE;
            if (state_reg.bit_cnt == ADDR_LAST) begin
              state_next.addr    = addr_byte;
              state_next.bit_cnt = '0;
              state_next.shin    = '0;
              state_next.phase   = PH_SKIP;
              if (addr_byte == ADDR_SOFT_RESET) begin
                state_next.soft_rst = 1'b1;
              end else if (allowed && addr_byte == ADDR_STATUS) begin
                state_next.shout   = status_now;
                state_next.is_read = 1'b1;
                state_next.phase   = PH_DATA;
                rd_cap             = 1'b1;
              end else if (allowed && (addr_byte == ADDR_IRQ_MASK
                           || addr_byte == ADDR_BIAS)) begin
                state_next.len     = LEN_BYTE;
                state_next.is_read = 1'b0;
                state_next.phase   = PH_DATA;
              end else if (allowed && (addr_byte == ADDR_CLOCK_CTRL
                           || addr_byte == ADDR_PLL_CFG_A
                           || addr_byte == ADDR_PLL_CFG_B)) begin
                state_next.len     = LEN_WORD;
                state_next.is_read = 1'b0;
                state_next.phase   = PH_DATA;
              end
            end
          end
        end
        PH_DATA: begin
          if (state_reg.is_read) begin
            if (sclk_fall) begin
              state_next.reply = state_reg.shout[ST_DONE];
              state_next.shout = {state_reg.shout[6:0], 1'b0};
            end
          end else if (sclk_rise) begin
            state_next.shin    = wr_word;
            state_next.bit_cnt = state_reg.bit_cnt + CNT_ONE;
            if (state_reg.bit_cnt == state_reg.len - CNT_ONE) begin
              wr_commit        = 1'b1;
              state_next.phase = PH_SKIP;
            end
          end
        end
        PH_SKIP: state_next.phase = PH_SKIP;
        default: state_next.phase = PH_IDLE;
      endcase
    end

    // Register writes
    if (wr_commit) begin
      case (state_reg.addr)
        ADDR_IRQ_MASK: state_next.mask = wr_word[7:0];
        ADDR_BIAS: state_next.bias = wr_word[7:0] & BIAS_WMSK;
        ADDR_CLOCK_CTRL: begin
          if (!state_reg.cc_lock) begin
            state_next.cc      = wr_word & CC_WMSK;
            state_next.cc_lock = 1'b1;
            state_next.div_cnt = '0;
            state_next.su_cnt  = '0;
          end
        end
        ADDR_PLL_CFG_A: if (!state_reg.cc_lock) state_next.pll_a = wr_word;
        ADDR_PLL_CFG_B: if (!state_reg.cc_lock) state_next.pll_b = wr_word;
        default: state_next.mask = state_reg.mask;
      endcase
    end

    // Startup delay counter on divider ticks
    if (state_reg.cc_lock && !state_reg.clk_run) begin
      state_next.div_cnt = div_tick ? '0 : state_reg.div_cnt + DIV_ONE;
      if (div_tick) begin
        if (state_reg.su_cnt == su_end) begin
          state_next.clk_run = 1'b1;
        end else begin
          state_next.su_cnt = state_reg.su_cnt + SU_ONE;
        end
      end
    end

    // Sticky bits: a set in the clearing cycle wins
    state_next.st_done = (state_reg.st_done & ~rd_cap) | done_set;
    state_next.st_conv = (state_reg.st_conv & ~rd_cap)
                         | status_src_i.conv_done;

    // Interrupt level from live status and mask
    state_next.irq = |(status_now & state_reg.mask);

    // Soft reset holds everything but the serial engine at reset
    if (state_reg.soft_rst) begin
      state_next.mask    = MASK_RST;
      state_next.bias    = BIAS_RST;
      state_next.cc      = CC_RST;
      state_next.pll_a   = PLL_RST;
      state_next.pll_b   = PLL_RST;
      state_next.cc_lock = 1'b0;
      state_next.div_cnt = '0;
      state_next.su_cnt  = '0;
      state_next.clk_run = 1'b0;
      state_next.st_done = 1'b0;
      state_next.st_conv = 1'b0;
      state_next.irq     = 1'b0;
      if (csn_rise) begin
        state_next.soft_rst = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign interrupt_out_n_o    = 1'b0;
  assign interrupt_oe_o       = state_reg.irq;
  assign reply_data_o         = state_reg.reply;
  assign midrail_bias_en_o    = state_reg.bias[BIAS_GEN];
  assign bias_buffer_en_o     = state_reg.bias[BIAS_BUF];
  assign buffered_bias_oe_o   = state_reg.bias[BIAS_BUF];
  assign clock_control_o      = state_reg.cc;
  assign clock_pll_config_a_o = state_reg.pll_a;
  assign clock_pll_config_b_o = state_reg.pll_b;
  assign clock_gen_on_o       = state_reg.cc_lock;
  assign sys_clk_enable_o     = state_reg.clk_run;
  assign soft_reset_o         = state_reg.soft_rst;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_irq_level: assert property ((|(status_now & state_reg.mask)) && !state_reg.soft_rst |=> interrupt_oe_o)
    else $error("interrupt not raised for enabled status");
  a_irq_enable: assert property ((|(status_now & state_reg.mask & ~$past(state_reg.mask)))
    && !state_reg.soft_rst |-> ##[1:2] interrupt_oe_o) else $error("enable rise did not raise interrupt");
  a_irq_release: assert property (!(|(status_now & state_reg.mask)) |=> !interrupt_oe_o)
    else $error("interrupt held without enabled status");
  a_od_drive: assert property (interrupt_oe_o |-> interrupt_out_n_o == 1'b0)
    else $error("interrupt driven high");
  a_read_clear: assert property (rd_cap && !done_set |=> !state_reg.st_done)
    else $error("startup done not cleared by read");
  a_clock_lock: assert property (state_reg.cc_lock && !state_reg.soft_rst |=> $stable(state_reg.cc))
    else $error("clock control changed while locked");
  a_clock_stop: assert property (!state_reg.cc_lock |-> !sys_clk_enable_o)
    else $error("system clock running before programming");
  a_soft_reset: assert property (state_reg.soft_rst |=> state_reg.mask == MASK_RST && !state_reg.cc_lock)
    else $error("soft reset did not restore defaults");
  a_bias_float: assert property (!state_reg.bias[BIAS_BUF] |-> !buffered_bias_oe_o)
    else $error("bias output driven while buffer off");
  a_done_flag: assert property (done_set && !state_reg.soft_rst |=> state_reg.st_done && sys_clk_enable_o)
    else $error("startup end did not set flag and clock");

  c_soft_reset: cover property ($rose(state_reg.soft_rst));
  c_clock_start: cover property ($rose(state_reg.clk_run));
  c_irq: cover property ($rose(interrupt_oe_o));
  c_status_read: cover property (rd_cap);

endmodule

`default_nettype wire

// ---- housekeeping_pkg.sv ----
// Constants, register map and carrier types for the housekeeping block.
// Assumes a single core clock domain; serial pins are synchronised inside.
package housekeeping_pkg;

  // Serial control port addresses
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h09;
  localparam logic [7:0] ADDR_BIAS       = 8'h10;
  localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h11;
  localparam logic [7:0] ADDR_PLL_CFG_A  = 8'h12;
  localparam logic [7:0] ADDR_PLL_CFG_B  = 8'h13;

  // Reset values and writable bits
  localparam logic [7:0]  MASK_RST  = 8'h80;
  localparam logic [7:0]  BIAS_RST  = 8'h00;
  localparam logic [7:0]  BIAS_WMSK = 8'h03;
  localparam logic [15:0] CC_RST    = 16'h0000;
  localparam logic [15:0] CC_WMSK   = 16'h3FFF;
  localparam logic [15:0] PLL_RST   = 16'h0000;

  // Field positions
  localparam int ST_DONE    = 7;
  localparam int ST_CONV    = 6;
  localparam int BIAS_GEN   = 1;
  localparam int BIAS_BUF   = 0;
  localparam int CC_SU_EN   = 13;
  localparam int CC_DLY_HI  = 12;
  localparam int CC_DLY_LO  = 8;
  localparam int CC_DIV_HI  = 7;
  localparam int CC_DIV_LO  = 1;

  // Serial framing counts and divider step
  localparam logic [4:0] ADDR_LAST = 5'h07;
  localparam logic [4:0] LEN_BYTE  = 5'h08;
  localparam logic [4:0] LEN_WORD  = 5'h10;
  localparam logic [4:0] CNT_ONE   = 5'h01;
  localparam logic [6:0] DIV_ONE   = 7'h01;

  // Startup counter
  localparam int          SU_W     = 21;
  localparam logic [21:0] SU_POW1  = 22'h00_0001;
  localparam logic [20:0] SU_ONE   = 21'h00_0001;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b11,
    PH_SKIP = 2'b10
  } port_phase_e;

  // Status sources from the surrounding circuits
  typedef struct packed {
    logic        conv_done;
    logic [7:0]  aux_converter_threshold_flags;
    logic [4:0]  comparator_crossing_flags;
    logic [4:0]  comparator_flag_enables;
    logic [1:0]  synth_one_state;
    logic [1:0]  synth_two_state;
    logic [15:0] receive_flags;
    logic [15:0] receive_flag_enables;
    logic [7:0]  transmit_flags;
    logic [7:0]  transmit_flag_enables;
  } status_src_s;

endpackage

// ---- host_port_model.sv ----
// Host processor model driving the serial control port of the housekeeping block.
// Assumes the core clock paces every pin change; six core cycles per serial phase.
`timescale 1ns/1ns
`default_nettype none

module host_port_model (
  input  wire logic core_clk_i,
  input  wire logic reply_data_i,
  output logic      serial_clock_o,
  output logic      serial_port_select_n_o,
  output logic      command_data_o
);
  // Idle pins: clock low and still, select released
  initial begin
    serial_clock_o         = 1'b0;
    serial_port_select_n_o = 1'b1;
    command_data_o         = 1'b0;
  end

  // One serial half period, long enough for the pin synchronisers
  task automatic phase();
    repeat (6) @(posedge core_clk_i);
  endtask

  // One frame: address, then nbits of data MSB first, reply shifted in
  task automatic xfer(input logic [7:0] addr, input logic [15:0] wdata, input int nbits,
                      output logic [15:0] rdata);
    logic [23:0] frame;
    frame = {addr, wdata << (16 - nbits)};
    rdata = 16'h0000;
    @(posedge core_clk_i);
    serial_port_select_n_o <= 1'b0;
    phase();
    for (int i = 0; i < 8 + nbits; i++) begin
      command_data_o <= frame[23 - i];
      phase();
      // Reply bit has stood since the last falling edge
      if (i >= 8) rdata = {rdata[14:0], reply_data_i};
      serial_clock_o <= 1'b1;
      phase();
      serial_clock_o <= 1'b0;
    end
    phase();
    serial_port_select_n_o <= 1'b1;
    // Released data line shows the inverse of its last value
    command_data_o <= ~command_data_o;
    phase();
  endtask
endmodule

`default_nettype wire

// ---- status_irq_reset_clock_startup_test.sv ----
// Self-checking bench for the housekeeping block with a serial host model.
// Assumes the design package, the design and the host model compile first.
`timescale 1ns/1ns
`default_nettype none

module status_irq_reset_clock_startup_test import housekeeping_pkg::*;;
  logic        core_clk_i, nrst_i, sclk, sel_n, cmd, reply;
  status_src_s src;
  logic        irq_out_n, irq_oe, bias_en, buf_en, buf_oe, gen_on, sys_en, soft_rst;
  logic [15:0] cc, pll_a, pll_b, rd;
  logic        irq_line, soft_seen;
  int          n_mismatch, n_compared, cycles, su_cnt;

  // Open-drain line with its pull-up
  assign irq_line = irq_oe ? irq_out_n : 1'b1;

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  housekeeping housekeeping_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .serial_clock_i(sclk),
    .serial_port_select_n_i(sel_n), .command_data_i(cmd), .reply_data_o(reply),
    .status_src_i(src), .interrupt_out_n_o(irq_out_n), .interrupt_oe_o(irq_oe),
    .midrail_bias_en_o(bias_en), .bias_buffer_en_o(buf_en), .buffered_bias_oe_o(buf_oe),
    .clock_control_o(cc), .clock_pll_config_a_o(pll_a), .clock_pll_config_b_o(pll_b),
    .clock_gen_on_o(gen_on), .sys_clk_enable_o(sys_en), .soft_reset_o(soft_rst));

  host_port_model host_port_model_inst (
    .core_clk_i(core_clk_i), .reply_data_i(reply), .serial_clock_o(sclk),
    .serial_port_select_n_o(sel_n), .command_data_o(cmd));

  // Startup length, soft reset inside a frame, and the hang limit
  always @(posedge core_clk_i) begin
    su_cnt <= (gen_on !== 1'b1) ? 0 : (sys_en !== 1'b1) ? su_cnt + 1 : su_cnt;
    if (soft_rst === 1'b1 && sel_n === 1'b0) soft_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic [15:0] d, input int n);
    host_port_model_inst.xfer(a, d, n, rd);
  endtask

  task automatic irq_is(input logic exp_line);
    repeat (3) @(posedge core_clk_i);
    chk_word(16'(irq_line), 16'(exp_line));
  endtask

  task automatic wait_started(input int lo, input int hi);
    for (int i = 0; i < 400 && sys_en !== 1'b1; i++) @(posedge core_clk_i);
    chk_word(16'(sys_en), 16'h0001);
    chk_word(16'(su_cnt >= lo && su_cnt <= hi), 16'h0001);
  endtask

  task automatic test_reset_values();
    chk_word(16'(irq_line), 16'h0001);
    chk_word(cc, 16'h0000);
    chk_word(16'({bias_en, buf_en, buf_oe}), 16'h0000);
    chk_word(16'({gen_on, sys_en, soft_rst}), 16'h0000);
  endtask

  task automatic test_refused();
    @(posedge core_clk_i);
    src.synth_one_state <= 2'b01;
    xfer(ADDR_BIAS, 16'h0003, 8);
    chk_word(16'({bias_en, buf_en}), 16'h0000);
    xfer(ADDR_IRQ_MASK, 16'h0004, 8);
    irq_is(1'b1);
    xfer(ADDR_STATUS, 16'h0000, 8);
    chk_word(rd, 16'h0004);
  endtask

  task automatic test_clock_start();
    xfer(ADDR_PLL_CFG_A, 16'h1234, 16);
    xfer(ADDR_PLL_CFG_B, 16'h5678, 16);
    xfer(ADDR_CLOCK_CTRL, 16'hE302, 16);
    chk_word(cc, 16'h2302);
    chk_word({pll_a ^ 16'h1234} | {pll_b ^ 16'h5678}, 16'h0000);
    chk_word(16'(gen_on), 16'h0001);
    wait_started(7, 10);
    irq_is(1'b0);
    xfer(ADDR_CLOCK_CTRL, 16'h0000, 16);
    xfer(ADDR_PLL_CFG_A, 16'h0000, 16);
    chk_word(cc ^ pll_a, 16'h2302 ^ 16'h1234);
  endtask

  task automatic test_status_read();
    xfer(ADDR_STATUS, 16'h0000, 8);
    chk_word(rd, 16'h0084);
    irq_is(1'b1);
    xfer(ADDR_STATUS, 16'h0000, 8);
    chk_word(rd, 16'h0004);
  endtask

  task automatic test_sources();
    xfer(ADDR_IRQ_MASK, 16'h0004, 8);
    irq_is(1'b0);
    src <= '0;
    irq_is(1'b1);
    xfer(ADDR_IRQ_MASK, 16'h007F, 8);
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk_i);
      case (k)
        0: src.transmit_flags[7] <= 1'b1;
        1: src.receive_flags[15] <= 1'b1;
        2: src.synth_one_state[1] <= 1'b1;
        3: src.synth_two_state[0] <= 1'b1;
        4: src.comparator_crossing_flags[4] <= 1'b1;
        default: src.aux_converter_threshold_flags[0] <= 1'b1;
      endcase
      src.transmit_flag_enables[7] <= 1'b1;
      src.receive_flag_enables[15] <= 1'b1;
      src.comparator_flag_enables[4] <= 1'b1;
      irq_is(1'b0);
      xfer(ADDR_STATUS, 16'h0000, 8);
      chk_word(rd, 16'h0001 << k);
      @(posedge core_clk_i);
      src <= '0;
      irq_is(1'b1);
    end
    @(posedge core_clk_i);
    src.conv_done <= 1'b1;
    @(posedge core_clk_i);
    src.conv_done <= 1'b0;
    xfer(ADDR_STATUS, 16'h0000, 8);
    chk_word(rd, 16'h0040);
    xfer(ADDR_STATUS, 16'h0000, 8);
    chk_word(rd, 16'h0000);
  endtask

  task automatic test_bias();
    xfer(ADDR_BIAS, 16'h00FF, 8);
    chk_word(16'({bias_en, buf_en, buf_oe}), 16'h0007);
    xfer(ADDR_BIAS, 16'h0002, 8);
    chk_word(16'({bias_en, buf_en, buf_oe}), 16'h0004);
  endtask

  task automatic test_soft_reset();
    soft_seen <= 1'b0;
    xfer(ADDR_SOFT_RESET, 16'h0000, 0);
    chk_word(16'({soft_seen, soft_rst}), 16'h0002);
    chk_word(cc, 16'h0000);
    chk_word(16'({gen_on, sys_en, bias_en}), 16'h0000);
    xfer(ADDR_CLOCK_CTRL, 16'h2000, 16);
    wait_started(127, 130);
    irq_is(1'b0);
    // Startup flag left disabled: clock starts, status stays clear
    xfer(ADDR_SOFT_RESET, 16'h0000, 0);
    xfer(ADDR_CLOCK_CTRL, 16'h0000, 16);
    wait_started(127, 130);
    irq_is(1'b1);
    xfer(ADDR_STATUS, 16'h0000, 8);
    chk_word(rd, 16'h0000);
  endtask

  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reset, then each scenario in turn
  initial begin
    nrst_i     = 1'b0;
    src        = '0;
    soft_seen  = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    cycles     = 0;
    su_cnt     = 0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    test_reset_values();
    test_refused();
    test_clock_start();
    test_status_read();
    test_sources();
    test_bias();
    test_soft_reset();
    end_sim();
  end
endmodule

`default_nettype wire
